// file: src/adcrt_core.sv
`timescale 1ns/100ps
module adcrt_core
    import adcrt_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic convert_strobe_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire logic [RESULT_W-1:0] sample_i,
    input wire logic [STATUS_W-1:0] status_i,
    input wire logic status_en_i,
    input wire logic reg_read_i,
    input wire logic [RESULT_W-1:0] reg_rdata_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic busy_o,
    output logic chain_mode_o,
    output logic result_valid_o,
    output logic [RESULT_W-1:0] result_o,
    output logic [RESULT_W-1:0] wr_data_o,
    output logic wr_strobe_o
);
    // Elaboration check: a count outside the window breaks the result timing
    if (CONV_CYCLES < CONV_MIN_CYC || CONV_CYCLES > CONV_MAX_CYC) begin : g_bad_conv
        $error("adcrt_core: CONV_CYCLES outside conversion window");
    end

    localparam int CW = $clog2(CONV_MAX_CYC + 1);
    localparam int BW = $clog2(FRAME_W + 1);

    // Synchronised pins
    logic cnv_lvl;
    logic cnv_rise;
    logic cnv_fall;
    logic sck_lvl;
    logic sck_rise;
    logic sck_fall;
    logic sdi_lvl;

    adcrt_sync u_cnv (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(convert_strobe_i),
        .level_o(cnv_lvl),
        .rise_o(cnv_rise),
        .fall_o(cnv_fall)
    );
    adcrt_sync u_sck (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(sck_i),
        .level_o(sck_lvl),
        .rise_o(sck_rise),
        .fall_o(sck_fall)
    );
    adcrt_sync u_sdi (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(sdi_i),
        .level_o(sdi_lvl),
        .rise_o(),
        .fall_o()
    );

    adcrt_state_e state_r;
    adcrt_state_e state_nxt;
    logic [CW-1:0] cnt_r;
    logic [FRAME_W-1:0] shift_r;
    logic [BW-1:0] bits_r;
    logic chain_r;
    logic sdo_r;
    logic oe_r;
    logic valid_r;
    logic [RESULT_W-1:0] result_r;
    logic [RESULT_W-1:0] wr_r;
    logic wr_stb_r;
    logic [BW-1:0] wr_bits_r;
    logic rd_r;
    logic busy_r;

    // Decode of events and frame control
    wire conv_done = (state_r == ADCRT_CONV) && (cnt_r == CW'(CONV_CYCLES - 1));
    wire [BW-1:0] frame_len = status_en_i ? BW'(FRAME_W) : BW'(RESULT_W);
    wire [FRAME_W-1:0] frame_load = status_en_i ? {sample_i, status_i}
                                                : {sample_i, STATUS_RST};
    wire sel_active = !chain_r && !cnv_lvl;
    wire chain_active = chain_r && cnv_lvl;
    wire shifting = (sel_active || chain_active) && (state_r == ADCRT_DONE || rd_r);
    wire last_fall = sck_fall && shifting && (bits_r == frame_len - BW'(1));
    wire wr_shift = sck_rise && !cnv_lvl && !chain_r && state_r == ADCRT_IDLE;
    wire wr_full = wr_shift && (wr_bits_r == BW'(RESULT_W - 1));
    // Rises during a conversion are ignored, mode and flags included
    wire start_ok = cnv_rise && (state_r != ADCRT_CONV);
    // Chain length follows the frame, so upstream bits land right behind it
    wire [FRAME_W-1:0] chain_long = {shift_r[FRAME_W-2:0], sdi_lvl};
    wire [FRAME_W-1:0] chain_short = {shift_r[FRAME_W-2:STATUS_W], sdi_lvl, STATUS_RST};
    wire [FRAME_W-1:0] chain_in = status_en_i ? chain_long : chain_short;

    // Conversion sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ADCRT_IDLE: if (cnv_rise) state_nxt = ADCRT_CONV;
            ADCRT_CONV: if (conv_done) state_nxt = ADCRT_DONE;
            ADCRT_DONE: if (cnv_rise) state_nxt = ADCRT_CONV;
            default: state_nxt = ADCRT_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ADCRT_IDLE;
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r <= (state_nxt == ADCRT_CONV); // Registered copy of the state decode
            cnt_r <= (state_r == ADCRT_CONV && !conv_done) ? cnt_r + CW'(1) : '0;
        end
    end

    // Mode pick: serial input level at the strobe rise
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            chain_r <= 1'b0;
            rd_r <= 1'b0;
        end else if (start_ok) begin
            chain_r <= !sdi_lvl;
            rd_r <= 1'b0;
        end else if (cnv_fall && reg_read_i && state_r != ADCRT_CONV) begin
            rd_r <= 1'b1;
        end
    end

    // Result shift path; chain mode pulls the upstream bits in behind
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_r <= '0;
            bits_r <= '0;
            valid_r <= 1'b0;
            result_r <= RESULT_RST;
        end else if (conv_done) begin
            shift_r <= frame_load;
            bits_r <= '0;
            valid_r <= 1'b1;
            result_r <= sample_i;
        end else if (cnv_fall && reg_read_i && state_r != ADCRT_CONV) begin
            shift_r <= {reg_rdata_i, STATUS_RST};
            bits_r <= '0;
        end else begin
            if (start_ok) valid_r <= 1'b0;
            if (sck_rise && chain_active && state_r == ADCRT_DONE)
                shift_r <= chain_in;
            else if (sck_fall && sel_active && shifting)
                shift_r <= {shift_r[FRAME_W-2:0], 1'b0};
            if (sck_fall && shifting && bits_r != frame_len)
                bits_r <= bits_r + BW'(1);
        end
    end

    // Output pin: one cycle after the synchronised edge, well past hold
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sdo_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            sdo_r <= shift_r[FRAME_W-1];
            if (chain_r)
                oe_r <= 1'b1; // Chain output always driven
            else if (cnv_fall) // Level still reads high while the fall is seen
                oe_r <= 1'b1;
            else if (cnv_lvl || last_fall)
                oe_r <= 1'b0;
        end
    end

    // Register write capture, sixteen bits most significant first
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_r <= '0;
            wr_bits_r <= '0;
            wr_stb_r <= 1'b0;
        end else begin
            wr_stb_r <= wr_full;
            if (cnv_rise)
                wr_bits_r <= '0;
            else if (wr_shift) begin
                wr_r <= {wr_r[RESULT_W-2:0], sdi_lvl};
                wr_bits_r <= wr_full ? '0 : wr_bits_r + BW'(1);
            end
        end
    end

    assign sdo_o = sdo_r;
    assign sdo_oe_o = oe_r;
    assign busy_o = busy_r;
    assign chain_mode_o = chain_r;
    assign result_valid_o = valid_r;
    assign result_o = result_r;
    assign wr_data_o = wr_r;
    assign wr_strobe_o = wr_stb_r;
endmodule : adcrt_core

// file: src/adcrt_pkg.sv
package adcrt_pkg;
    // Core clock period in picoseconds (100 MHz)
    localparam int CLK_PERIOD_PS = 10000;
    // Conversion duration window, ns
    localparam int CONV_MIN_NS = 270;
    localparam int CONV_MAX_NS = 320;
    // Least time rounds up, longest rounds down
    localparam int CONV_MIN_CYC = (CONV_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CONV_MAX_CYC = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
    // Conversion length used by the block, inside the window
    localparam int CONV_CYC = CONV_MAX_CYC;
    // Result and status widths
    localparam int RESULT_W = 16;
    localparam int STATUS_W = 6;
    localparam int FRAME_W = RESULT_W + STATUS_W;
    // Reset values
    localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
    localparam logic [STATUS_W-1:0] STATUS_RST = 6'h00;

    typedef enum logic [1:0] {
        ADCRT_IDLE = 2'b00,
        ADCRT_CONV = 2'b01,
        ADCRT_DONE = 2'b10
    } adcrt_state_e;
endpackage : adcrt_pkg

// file: src/adcrt_sync.sv
`timescale 1ns/100ps
// Three-stage synchroniser; a change counts when stages two and three agree
module adcrt_sync (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic agree;
    logic lvl_nxt;

    assign agree = (s2_r == s3_r);
    assign lvl_nxt = agree ? s3_r : lvl_r;
    assign level_o = lvl_r;
    assign rise_o = agree && s3_r && !lvl_r;
    assign fall_o = agree && !s3_r && lvl_r;

    // Stage one feeds stage two only
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end
endmodule : adcrt_sync

// file: bench/adcrt_assertions.sv
`timescale 1ns/100ps
// Watches conversion timing, output enable and write pulse
module adcrt_assertions #(
    parameter int CONV_CYCLES = 32
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic convert_strobe_i,
    input wire logic busy_o,
    input wire logic chain_mode_o,
    input wire logic result_valid_o,
    input wire logic [15:0] result_o,
    input wire logic sdo_oe_o,
    input wire logic wr_strobe_o
);
    // Window around the conversion length, slack for the pin synchroniser
    localparam int LO = CONV_CYCLES - 6;
    localparam int HI = CONV_CYCLES + 1;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    conv_done_a: assert property ($rose(busy_o) |-> ##[LO:HI] $rose(result_valid_o))
        else $error("result late");
    conv_min_a: assert property ($rose(busy_o) |-> ##2 (!result_valid_o)[*8])
        else $error("result early");
    valid_clr_a: assert property ($rose(busy_o) |-> ##[0:1] !result_valid_o)
        else $error("valid kept");
    res_hold_a: assert property ($changed(result_o) |-> ##[0:1] result_valid_o)
        else $error("result moved");
    mode_hold_a: assert property (busy_o && $past(busy_o) |-> $stable(chain_mode_o))
        else $error("mode moved");
    out_float_a: assert property (convert_strobe_i && !chain_mode_o |-> ##[0:6] !sdo_oe_o)
        else $error("output kept");
    out_drive_a: assert property ($fell(convert_strobe_i) && !busy_o && !chain_mode_o
        |-> ##[3:6] sdo_oe_o)
        else $error("output late");
    wr_pulse_a: assert property (wr_strobe_o |=> !wr_strobe_o)
        else $error("long write");
endmodule : adcrt_assertions

bind adcrt_core adcrt_assertions #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.core_clk_i, .rst_i,
    .convert_strobe_i, .busy_o, .chain_mode_o, .result_valid_o, .result_o, .sdo_oe_o,
    .wr_strobe_o);

// file: bench/adcrt_host.sv
`timescale 1ns/100ps
// Host model: one start, then a frame of serial clocks at 160 ns
module adcrt_host (
    input wire logic core_clk_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic convert_strobe_o,
    output logic sck_o,
    output logic sdi_o
);
    logic [31:0] tx = 32'h0;
    logic chain_r = 1'b0;
    initial {convert_strobe_o, sck_o, sdi_o} = 3'b001;
    // Low, then a rise with the mode level settled well before it
    task automatic start(input logic chain);
        chain_r = chain;
        convert_strobe_o <= 1'b0;
        sdi_o <= ~chain;
        repeat (6) @(posedge core_clk_i);
        convert_strobe_o <= 1'b1;
        repeat (44) @(posedge core_clk_i);
    endtask : start
    // Sample before each rise; a floating output reads as unknown
    task automatic frame(input int n, output logic [31:0] rx);
        logic [31:0] sh;
        sh = tx;
        rx = 32'h0;
        if (!chain_r) convert_strobe_o <= 1'b0;
        sdi_o <= sh[31];
        repeat (8) @(posedge core_clk_i);
        for (int i = 0; i < n; i++) begin
            rx = {rx[30:0], sdo_oe_i ? sdo_i : 1'bx};
            sck_o <= 1'b1;
            repeat (8) @(posedge core_clk_i);
            sh = sh << 1;
            sck_o <= 1'b0;
            sdi_o <= sh[31];
            repeat (8) @(posedge core_clk_i);
        end
    endtask : frame
endmodule : adcrt_host

// file: bench/tb.sv
`timescale 1ns/100ps
// Host model drives the pins; a monitor compares each result with its note
module tb;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic convert_strobe_i, sck_i, sdi_i, status_en_i, reg_read_i, vld_q;
    logic sdo_o, sdo_oe_o, busy_o, chain_mode_o, result_valid_o, wr_strobe_o;
    logic [15:0] sample_i, reg_rdata_i, result_o, wr_data_o;
    logic [5:0] status_i;
    logic [31:0] rx;
    logic [31:0] q[$];
    logic [15:0] wq[$];
    int num_errors = 0;
    int checked = 0;
    event got;
    always #5 core_clk_i = ~core_clk_i;
    adcrt_core i_dut (.core_clk_i, .rst_i, .convert_strobe_i, .sck_i, .sdi_i, .sample_i,
        .status_i, .status_en_i, .reg_read_i, .reg_rdata_i, .sdo_o, .sdo_oe_o, .busy_o,
        .chain_mode_o, .result_valid_o, .result_o, .wr_data_o, .wr_strobe_o);
    adcrt_host i_host (.core_clk_i, .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o),
        .convert_strobe_o(convert_strobe_i), .sck_o(sck_i), .sdi_o(sdi_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // Register write; only possible before the first conversion after reset
    task automatic write_word();
        i_host.tx = {16'($urandom), 16'hFFFF};
        wq.push_back(i_host.tx[31:16]);
        i_host.frame(16, rx);
    endtask : write_word
    // Monitor: each new result takes the oldest note
    always @(posedge core_clk_i) begin
        vld_q <= result_valid_o;
        if (result_valid_o && !vld_q) check({16'h0, result_o}, q.pop_front());
        if (wr_strobe_o) check({16'h0, wr_data_o}, {16'h0, wq.pop_front()});
    end
    always @got check(rx, q.pop_front());
    // Twelve frames cycling through the four readout kinds
    initial begin
        int mode;
        {status_en_i, reg_read_i} = 2'b00;
        {sample_i, reg_rdata_i, status_i} = 38'h0;
        void'($urandom(14));
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        write_word();
        for (int k = 0; k < 12; k++) begin
            mode = k % 4;
            @(posedge core_clk_i);
            sample_i <= 16'($urandom);
            reg_rdata_i <= 16'($urandom);
            status_i <= 6'($urandom);
            status_en_i <= (mode == 1);
            reg_read_i <= (mode == 3);
            i_host.tx = {16'($urandom), 16'hFFFF};
            @(posedge core_clk_i);
            q.push_back({16'h0, sample_i});
            i_host.start(mode == 2);
            check({31'h0, chain_mode_o}, {31'h0, mode == 2});
            case (mode)
                0: q.push_back({16'h0, sample_i});
                1: q.push_back({10'h0, sample_i, status_i});
                2: q.push_back({sample_i, i_host.tx[31:16]});
                default: q.push_back({16'h0, reg_rdata_i});
            endcase
            i_host.frame(mode == 1 ? 22 : mode == 2 ? 32 : 16, rx);
            -> got;
        end
        // Second reset after the twelve frames, then a fresh write from the idle state
        rst_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        write_word();
        repeat (8) @(posedge core_clk_i);
        check(q.size() + wq.size(), 0);
        report_and_stop();
    end
    // Watchdog well past twelve frames
    initial begin
        #150000;
        num_errors++;
        report_and_stop();
    end
endmodule : tb
